//--- hdl/io_port5.sv
// Eight-pin general I/O port with wake-up, trigger and I2C pin sharing.
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Function-select bit 0 high turns pin zero into active-low wake input zero.
// - Function-select bit 1 high turns pin one into wake input one.
// - A general-purpose pin drives its output when its direction bit is 1.
// - Direction register is write-only, one bit per pin, resets to zero.
// - Output data register is read/write, drives output pins, resets to zero.
// - Data reads return the stored bit where direction is 1.
// - Data reads return the synchronised pin level where direction is 0.
// - Pull-ups 5..0 act only on pins whose direction bit is 0.
// - Pull-up enable 1 switches the pull-up on, 0 off; reset zero.
// - Pull-up bits 7 and 6 ignore writes and read as zero.
// - I2C enable makes pin seven the open-drain clock line regardless of direction.
// - I2C enable makes pin six the open-drain data line regardless of direction.
module io_port5
  import port5_pkg::*;
#(
  parameter int ADDR_WIDTH = 8,
  parameter int PIN_COUNT = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_WIDTH-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_WIDTH-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Package pins
  input wire logic [PIN_COUNT-1:0] pad_in,
  output logic [PIN_COUNT-1:0] pad_out,
  output logic [PIN_COUNT-1:0] pad_oe,
  output logic [PIN_COUNT-1:0] pullup_on,
  // Alternate functions
  output logic [5:0] wake_in_n,
  output logic adc_ext_trigger_n,
  input wire logic i2c_scl_drive_low,
  input wire logic i2c_sda_drive_low,
  output logic i2c_scl_in,
  output logic i2c_sda_in
);

  // Register state.
  logic [7:0] direction_q;
  logic [7:0] direction_d;
  logic [7:0] output_data_q;
  logic [7:0] output_data_d;
  logic [7:0] pullup_enable_q;
  logic [7:0] pullup_enable_d;
  logic [7:0] function_select_q;
  logic [7:0] function_select_d;
  logic i2c_enable_q;
  logic i2c_enable_d;

  // Write channel state.
  logic aw_held_q;
  logic aw_held_d;
  logic [ADDR_WIDTH-1:0] aw_addr_q;
  logic [ADDR_WIDTH-1:0] aw_addr_d;
  logic w_held_q;
  logic w_held_d;
  logic [7:0] w_byte_q;
  logic [7:0] w_byte_d;
  logic w_lane0_q;
  logic w_lane0_d;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;

  // Read channel state.
  logic rvalid_q;
  logic rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;

  logic [PIN_COUNT-1:0] pin_level;
  logic commit_write;
  logic [7:0] pin_readback;
  logic [7:0] gpio_drive;

  pin_sync #(
    .WIDTH(PIN_COUNT)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(pad_in),
    .sync_out(pin_level)
  );

  // Decodes a bus address to one of the mapped register offsets.
  function automatic logic is_reg(input logic [ADDR_WIDTH-1:0] addr, input logic [7:0] offset);
    is_reg = (addr[ADDR_WIDTH-1:2] == offset[ADDR_WIDTH-1:2]);
  endfunction : is_reg

  // Merges lane 0 of a write into an eight-bit register, honouring the writable mask.
  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] data,
                                            input logic lane, input logic [7:0] mask);
    merge_byte = lane ? ((data & mask) | (old & ~mask)) : old;
  endfunction : merge_byte

  function automatic logic is_mapped(input logic [ADDR_WIDTH-1:0] addr);
    is_mapped = is_reg(addr, DIRECTION_OFFSET) || is_reg(addr, OUTPUT_DATA_OFFSET) ||
                is_reg(addr, PULLUP_ENABLE_OFFSET) || is_reg(addr, PIN_FUNCTION_SELECT_OFFSET) ||
                is_reg(addr, I2C_CONTROL_OFFSET) || is_reg(addr, PIN_LEVEL_OFFSET);
  endfunction : is_mapped

  // Write channel: address and data are taken independently, then committed together.
  always_comb begin
    awready = !aw_held_q && !bvalid_q;
    wready = !w_held_q && !bvalid_q;
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d = w_held_q;
    w_byte_d = w_byte_q;
    w_lane0_d = w_lane0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    commit_write = aw_held_q && w_held_q && !bvalid_q;
    if (awvalid && awready) begin
      aw_held_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_held_d = 1'b1;
      w_byte_d = wdata[7:0];
      w_lane0_d = wstrb[0];
    end
    if (commit_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = is_mapped(aw_addr_q) && !is_reg(aw_addr_q, PIN_LEVEL_OFFSET) ?
                RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
  end

  // Register updates on a committed write.
  always_comb begin
    direction_d = direction_q;
    output_data_d = output_data_q;
    pullup_enable_d = pullup_enable_q;
    function_select_d = function_select_q;
    i2c_enable_d = i2c_enable_q;
    if (commit_write) begin
      if (is_reg(aw_addr_q, DIRECTION_OFFSET)) begin
        direction_d = merge_byte(direction_q, w_byte_q, w_lane0_q, 8'hff);
      end
      if (is_reg(aw_addr_q, OUTPUT_DATA_OFFSET)) begin
        output_data_d = merge_byte(output_data_q, w_byte_q, w_lane0_q, 8'hff);
      end
      if (is_reg(aw_addr_q, PULLUP_ENABLE_OFFSET)) begin
        pullup_enable_d = merge_byte(pullup_enable_q, w_byte_q, w_lane0_q,
                                     PULLUP_VALID_MASK);
      end
      if (is_reg(aw_addr_q, PIN_FUNCTION_SELECT_OFFSET)) begin
        function_select_d = merge_byte(function_select_q, w_byte_q, w_lane0_q,
                                       FUNCTION_SELECT_MASK);
      end
      if (is_reg(aw_addr_q, I2C_CONTROL_OFFSET) && w_lane0_q) begin
        i2c_enable_d = w_byte_q[I2C_ENABLE_BIT];
      end
    end
  end

  // Output pins read back their stored value, input pins their sampled level.
  assign pin_readback = (output_data_q & direction_q) | (pin_level & ~direction_q);

  // Read channel: one address at a time, data registered at acceptance.
  always_comb begin
    arready = !rvalid_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rdata_d = 32'h0000_0000;
      rresp_d = RESP_OKAY;
      if (is_reg(araddr, OUTPUT_DATA_OFFSET)) begin
        rdata_d[7:0] = pin_readback;
      end else if (is_reg(araddr, PULLUP_ENABLE_OFFSET)) begin
        rdata_d[7:0] = pullup_enable_q & PULLUP_VALID_MASK;
      end else if (is_reg(araddr, PIN_FUNCTION_SELECT_OFFSET)) begin
        rdata_d[7:0] = function_select_q;
      end else if (is_reg(araddr, I2C_CONTROL_OFFSET)) begin
        rdata_d[I2C_ENABLE_BIT] = i2c_enable_q;
      end else if (is_reg(araddr, PIN_LEVEL_OFFSET)) begin
        rdata_d[7:0] = pin_level;
      end else if (!is_reg(araddr, DIRECTION_OFFSET)) begin
        rresp_d = RESP_SLVERR;
      end
      // The direction register is write-only and reads as zero.
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      direction_q <= DIRECTION_RESET;
      output_data_q <= OUTPUT_DATA_RESET;
      pullup_enable_q <= PULLUP_ENABLE_RESET;
      function_select_q <= PIN_FUNCTION_SELECT_RESET;
      i2c_enable_q <= I2C_ENABLE_RESET;
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_held_q <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else begin
      direction_q <= direction_d;
      output_data_q <= output_data_d;
      pullup_enable_q <= pullup_enable_d;
      function_select_q <= function_select_d;
      i2c_enable_q <= i2c_enable_d;
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q <= w_held_d;
      w_byte_q <= w_byte_d;
      w_lane0_q <= w_lane0_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // Pin multiplexing. A pin handed to an input function never drives, whatever its
  // direction bit says, so a stale direction cannot fight an external wake source.
  always_comb begin
    gpio_drive = direction_q & ~function_select_q;
    pad_out = output_data_q;
    pad_oe = gpio_drive;
    if (i2c_enable_q) begin
      pad_out[SCL_PIN] = 1'b0;
      pad_oe[SCL_PIN] = i2c_scl_drive_low;
      pad_out[SDA_PIN] = 1'b0;
      pad_oe[SDA_PIN] = i2c_sda_drive_low;
    end
    pullup_on = pullup_enable_q & PULLUP_VALID_MASK & ~direction_q;
    // Unselected wake inputs idle high, which is their inactive level.
    wake_in_n = pin_level[5:0] | ~function_select_q[5:0];
    adc_ext_trigger_n = pin_level[WAKE_FIVE_BIT] | ~function_select_q[WAKE_FIVE_BIT];
    // Bus levels idle high while the interface is off, as a released bus would.
    i2c_scl_in = pin_level[SCL_PIN] | ~i2c_enable_q;
    i2c_sda_in = pin_level[SDA_PIN] | ~i2c_enable_q;
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_wake_zero: assert property (function_select_q[WAKE_ZERO_BIT] |->
      !pad_oe[0] && wake_in_n[0] == pin_level[0])
    else $error("pin zero drives or misroutes while used as wake input");

  chk_wake_one: assert property (function_select_q[WAKE_ONE_BIT] |->
      !pad_oe[1] && wake_in_n[1] == pin_level[1])
    else $error("pin one drives or misroutes while used as wake input");

  chk_gpio_drive: assert property (!function_select_q[2] && direction_q[2] |->
      pad_oe[2] && pad_out[2] == output_data_q[2])
    else $error("general output pin two is not driven with its data");

  chk_dir_reset: assert property ($past(!aresetn) |-> direction_q == 8'h00)
    else $error("direction register not clear after reset");

  chk_data_reset: assert property ($past(!aresetn) |->
      output_data_q == 8'h00 && pad_oe == 8'h00)
    else $error("data register or drivers not clear after reset");

  chk_read_stored: assert property (arvalid && arready &&
      is_reg(araddr, OUTPUT_DATA_OFFSET) |=>
      ((rdata[7:0] ^ $past(output_data_q)) & $past(direction_q)) == 8'h00)
    else $error("data read of an output bit lost the stored value");

  chk_read_pin: assert property (arvalid && arready &&
      is_reg(araddr, OUTPUT_DATA_OFFSET) |=>
      ((rdata[7:0] ^ $past(pin_level)) & ~$past(direction_q)) == 8'h00)
    else $error("data read of an input bit did not return the pin level");

  chk_pullup_output: assert property ((pullup_on & direction_q) == 8'h00)
    else $error("pull-up on while its pin is an output");

  chk_pullup_write: assert property (commit_write && w_lane0_q &&
      is_reg(aw_addr_q, PULLUP_ENABLE_OFFSET) && direction_q == 8'h00 ##1
      direction_q == 8'h00 |-> pullup_on == ($past(w_byte_q) & 8'h3f))
    else $error("pull-up enable write did not reach the pins");

  chk_pullup_reserved: assert property (rvalid && $rose(rvalid) &&
      $past(is_reg(araddr, PULLUP_ENABLE_OFFSET)) |-> rdata[7:6] == 2'h0)
    else $error("reserved pull-up bits read as nonzero");

  chk_scl_opendrain: assert property (i2c_enable_q |-> !pad_out[7] &&
      pad_oe[7] == i2c_scl_drive_low)
    else $error("clock pin not open-drain under the I2C interface");

  chk_sda_opendrain: assert property (i2c_enable_q |-> !pad_out[6] &&
      pad_oe[6] == i2c_sda_drive_low)
    else $error("data pin not open-drain under the I2C interface");

  chk_trigger_five: assert property (function_select_q[WAKE_FIVE_BIT] |->
      !pad_oe[5] && adc_ext_trigger_n == pin_level[5] && wake_in_n[5] == pin_level[5])
    else $error("pin five not routed to wake and trigger input");

endmodule : io_port5
`default_nettype wire

//--- hdl/port5_pkg.sv
// Register map, field layout and reset values of the eight-pin I/O port.
package port5_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] DIRECTION_OFFSET = 8'h00;
  localparam logic [7:0] OUTPUT_DATA_OFFSET = 8'h04;
  localparam logic [7:0] PULLUP_ENABLE_OFFSET = 8'h08;
  localparam logic [7:0] PIN_FUNCTION_SELECT_OFFSET = 8'h0c;
  localparam logic [7:0] I2C_CONTROL_OFFSET = 8'h10;
  localparam logic [7:0] PIN_LEVEL_OFFSET = 8'h14;

  // Reset values.
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [7:0] OUTPUT_DATA_RESET = 8'h00;
  localparam logic [7:0] PULLUP_ENABLE_RESET = 8'h00;
  localparam logic [7:0] PIN_FUNCTION_SELECT_RESET = 8'h00;
  localparam logic I2C_ENABLE_RESET = 1'b0;

  // Writable bit masks and field positions.
  localparam logic [7:0] PULLUP_VALID_MASK = 8'h3f;
  localparam logic [7:0] FUNCTION_SELECT_MASK = 8'h3f;
  localparam int I2C_ENABLE_BIT = 0;
  localparam int WAKE_ZERO_BIT = 0;
  localparam int WAKE_ONE_BIT = 1;
  localparam int WAKE_FIVE_BIT = 5;
  localparam int SDA_PIN = 6;
  localparam int SCL_PIN = 7;

  // Input synchroniser depth.
  localparam int SYNC_STAGES = 2;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : port5_pkg

//--- hdl/pin_sync.sv
// Two-flop synchroniser for a vector of asynchronous pin levels.
`timescale 1ns/10ps
`default_nettype none
module pin_sync
  import port5_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage1_d;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage2_d;

  always_comb begin
    stage1_d = async_in;
    stage2_d = stage1_q;
  end

  // The first stage feeds only the second, so metastability never reaches logic.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
    end
  end

  assign sync_out = stage2_q;

endmodule : pin_sync
`default_nettype wire

//--- verification/pin_board_model.sv
// Behavioural model of the board around the port pins: drivers, pull-ups and floating lines.
`timescale 1ns/10ps
`default_nettype none
module pin_board_model #(
  parameter logic [7:0] BUS_PULLUP = 8'hc0
) (
  // Clock
  input wire logic aclk,
  // Port side
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pullup_on,
  // Board side
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_level,
  output logic [7:0] pad_in
);
  // A line nobody drives or pulls keeps toggling, so no check can lean on a stale level.
  logic [7:0] float_q;
  initial float_q = 8'h5a;
  always @(posedge aclk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_level[i];
      else if (pullup_on[i] || BUS_PULLUP[i]) pad_in[i] = 1'b1;
      else pad_in[i] = float_q[i];
    end
  end
endmodule : pin_board_model
`default_nettype wire

//--- verification/test_eight_bit_io_port_with_wakeup_mux.sv
// Self-checking bench for the eight-pin I/O port with wake-up and I2C pin sharing.
`timescale 1ns/10ps
`default_nettype none
module test_eight_bit_io_port_with_wakeup_mux;
  import port5_pkg::*;
  // The full eight-pin package is modelled, so bits 7 and 6 may be set.
  localparam logic [7:0] PKG_MASK = 8'hff;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, adc_ext_trigger_n;
  logic scl_low, sda_low, i2c_scl_in, i2c_sda_in;
  logic [7:0] awaddr, araddr, ext_en, ext_level, pad_in, pad_out, pad_oe, pullup_on;
  logic [7:0] dir, dat, pu, lvl;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [5:0] wake_in_n;
  int errors, cmp_count, seed;

  io_port5 dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pullup_on(pullup_on), .wake_in_n(wake_in_n), .adc_ext_trigger_n(adc_ext_trigger_n),
    .i2c_scl_drive_low(scl_low), .i2c_sda_drive_low(sda_low), .i2c_scl_in(i2c_scl_in),
    .i2c_sda_in(i2c_sda_in));

  pin_board_model board (.aclk(aclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pullup_on(pullup_on), .ext_en(ext_en), .ext_level(ext_level), .pad_in(pad_in));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] exp_data(input logic [7:0] d, input logic [7:0] v,
                                           input logic [7:0] l);
    return {24'h0, (v & d) | (l & ~d)};
  endfunction : exp_data

  // Handshakes are sampled at the falling edge, where nothing is in motion.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_hs, w_hs, b_hs;
    logic [1:0] r;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) begin
        check(32'(r), 32'(er));
        return;
      end
    end
    errors++;
    tally_and_finish();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic ar_hs, r_hs;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      r_hs = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) begin
        check(d, exp);
        check(32'(r), 32'(er));
        return;
      end
    end
    errors++;
    tally_and_finish();
  endtask : rd

  initial begin
    seed = 9;
    errors = 0;
    cmp_count = 0;
    {aresetn, awvalid, wvalid, arvalid, scl_low, sda_low} = 6'h0;
    bready = 1'b1;
    rready = 1'b1;
    {awaddr, araddr, ext_level} = 24'h0;
    ext_en = 8'hff;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    check(32'(pad_oe), 32'h0);
    rd(DIRECTION_OFFSET, 32'h0, RESP_OKAY);
    rd(OUTPUT_DATA_OFFSET, 32'h0, RESP_OKAY);
    rd(PULLUP_ENABLE_OFFSET, 32'h0, RESP_OKAY);
    for (int k = 0; k < 24; k++) begin
      dir = 8'($random(seed)) & PKG_MASK;
      dat = 8'($random(seed)) & PKG_MASK;
      pu = 8'($random(seed));
      lvl = 8'($random(seed));
      if (k < 2) begin
        dir = k ? 8'h00 : 8'hff;
        pu = 8'hff;
      end
      ext_en <= ~dir;
      ext_level <= lvl;
      wr(DIRECTION_OFFSET, dir, RESP_OKAY);
      wr(OUTPUT_DATA_OFFSET, dat, RESP_OKAY);
      wr(PULLUP_ENABLE_OFFSET, pu, RESP_OKAY);
      repeat (3) @(posedge aclk);
      check(32'(pad_oe), 32'(dir));
      check(32'(pad_out & dir), 32'(dat & dir));
      check(32'(pullup_on), 32'(pu & ~dir & 8'h3f));
      rd(PULLUP_ENABLE_OFFSET, 32'(pu & 8'h3f), RESP_OKAY);
      rd(OUTPUT_DATA_OFFSET, exp_data(dir, dat, lvl), RESP_OKAY);
      rd(DIRECTION_OFFSET, 32'h0, RESP_OKAY);
    end
    wr(DIRECTION_OFFSET, 8'hff, RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      lvl = k ? 8'h02 : 8'h21;
      ext_en <= 8'h23;
      ext_level <= lvl;
      wr(PIN_FUNCTION_SELECT_OFFSET, 8'h23, RESP_OKAY);
      repeat (3) @(posedge aclk);
      check(32'(pad_oe & 8'h23), 32'h0);
      check(32'(wake_in_n), 32'({lvl[5], 3'h7, lvl[1:0]}));
      check(32'(adc_ext_trigger_n), 32'(lvl[5]));
      rd(PIN_FUNCTION_SELECT_OFFSET, 32'h23, RESP_OKAY);
      // Selected pins show the board level, the rest their own driven data.
      rd(PIN_LEVEL_OFFSET, 32'((lvl & 8'h23) | (dat & 8'hdc)), RESP_OKAY);
    end
    wr(PIN_FUNCTION_SELECT_OFFSET, 8'h00, RESP_OKAY);
    check(32'(wake_in_n), 32'h3f);
    check(32'(pad_oe), 32'hff);
    dat = 8'($random(seed));
    wr(OUTPUT_DATA_OFFSET, dat, RESP_OKAY);
    ext_en <= 8'h00;
    wr(I2C_CONTROL_OFFSET, 8'h01, RESP_OKAY);
    rd(I2C_CONTROL_OFFSET, 32'h1, RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      // The second pass clears the direction bits, which the bus pins must ignore.
      wr(DIRECTION_OFFSET, k ? 8'h3f : 8'hff, RESP_OKAY);
      scl_low <= k[0];
      sda_low <= ~k[0];
      repeat (4) @(posedge aclk);
      check(32'(pad_oe[7:6]), 32'({scl_low, sda_low}));
      check(32'(pad_out[7:6]), 32'h0);
      check(32'(i2c_scl_in), 32'(!scl_low));
      check(32'(i2c_sda_in), 32'(!sda_low));
    end
    wr(DIRECTION_OFFSET, 8'hff, RESP_OKAY);
    wr(I2C_CONTROL_OFFSET, 8'h00, RESP_OKAY);
    check(32'({i2c_scl_in, i2c_sda_in}), 32'h3);
    check(32'(pad_oe[7:6]), 32'h3);
    check(32'(pad_out[7:6]), 32'(dat[7:6]));
    rd(8'h18, 32'h0, RESP_SLVERR);
    wr(PIN_LEVEL_OFFSET, 8'hff, RESP_SLVERR);
    tally_and_finish();
  end
endmodule : test_eight_bit_io_port_with_wakeup_mux
`default_nettype wire
